// ### common/ref_input_pkg.sv
// ==========================================================================
// Function
// - load cap code bits 12:8, reset 0bh
// - bias code bits 5:2, reset 5h
// - input buffer select bits 1:0, reset 0
// - bits 7:6 reserved read-write, reset zero
// - second word at 1bh, resets zero
// - second word field layout, bit 15 reserved
// - bypass enable bit turns channel buffer on
// - source select: 0 raw ref, 1 pfd
// - divider reset held during any reset
// - divider zero doubles, n divides by n
package ref_input_pkg;
   // ======================================================================
   // register addresses
   localparam logic [7:0]  addr_crystal_cfg   = 8'h1a; // crystal and buffer word
   localparam logic [7:0]  addr_bypass_rdiv   = 8'h1b; // bypass and divider word
   // ======================================================================
   // reset values
   localparam logic [15:0] crystal_cfg_reset  = 16'h0b14; // 0bh load, 5h bias, 0 buffer
   localparam logic [15:0] bypass_rdiv_reset  = 16'h0000; // all zero
   // ======================================================================
   // field positions, first word
   localparam int          cload_lsb          = 8;   // load cap code low bit
   localparam int          cload_msb          = 12;  // load cap code high bit
   localparam int          resv_lsb           = 6;   // reserved pair low bit
   localparam int          resv_msb           = 7;   // reserved pair high bit
   localparam int          bias_lsb           = 2;   // bias code low bit
   localparam int          bias_msb           = 5;   // bias code high bit
   localparam int          inbuf_lsb          = 0;   // buffer select low bit
   localparam int          inbuf_msb          = 1;   // buffer select high bit
   localparam int          upper_lsb          = 13;  // upper fields kept elsewhere
   localparam int          upper_msb          = 15;
   // ======================================================================
   // field positions, second word
   localparam int          byp_resv_bit       = 15;  // reserved
   localparam int          byp_chan_lsb       = 11;  // channel one enable
   localparam int          byp_chan_msb       = 14;  // channel four enable
   localparam int          ref_copy_en_bit    = 10;  // reference copy output enable
   localparam int          ref_copy_sel_bit   = 9;   // reference copy source select
   localparam int          rdiv_rst_bit       = 8;   // divider reset
   localparam int          rdiv_lsb           = 0;
   localparam int          rdiv_msb           = 7;
   // ======================================================================
   // codes
   localparam logic [3:0]  bias_disabled      = 4'h0; // oscillator bias off
   localparam logic [1:0]  inbuf_crystal      = 2'h0; // crystal oscillator mode
   localparam logic [7:0]  rdiv_doubler       = 8'h00; // doubler instead of divider
   localparam int          num_chan           = 4;    // bypass channels
endpackage

// ### src/bypass_buf_gate.sv
// ==========================================================================
// one channel bypass buffer gate: routes bypass clock only when enabled
module bypass_buf_gate (
   input  wire logic mclk,        // digital clock
   input  wire logic rst,         // synchronous reset
   input  wire logic buf_en,      // enable bit from register
   input  wire logic byp_src,     // bypass request from channel mux
   output logic      buf_on,      // buffer powered
   output logic      byp_route    // bypass signal reaches mux
);
   // ======================================================================
   // registered buffer state
   always_ff @(posedge mclk) begin
      if (rst) begin
         buf_on    <= 1'b0;
         byp_route <= 1'b0;
      end else begin
         buf_on    <= buf_en;
         byp_route <= buf_en & byp_src;
      end
   end
endmodule

// ### src/ref_input_config_regs.sv
// ==========================================================================
// reference input configuration register slice
module ref_input_config_regs (
   input  wire logic        mclk,                     // digital clock, 10 MHz
   input  wire logic        rst,                      // synchronous reset, high
   input  wire logic        sw_reset,                 // software reset request
   input  wire logic        pin_reset,                // reset pin level, async
   input  wire logic [7:0]  reg_addr,                 // register address
   input  wire logic        reg_wr,                   // write strobe
   input  wire logic        reg_rd,                   // read strobe
   input  wire logic [15:0] reg_wdata,                // write data
   output logic      [15:0] reg_rdata,                // read data
   output logic             reg_hit,                  // read address decodes here
   input  wire logic [3:0]  chan_byp_req,             // per channel bypass request
   input  wire logic        ref_clk_sel_in,           // raw reference level
   input  wire logic        phase_detector_clock,     // phase detector level
   output logic      [4:0]  crystal_load_cap_sel,     // load cap code
   output logic      [3:0]  crystal_bias_sel,         // bias code
   output logic      [1:0]  input_buffer_sel,         // buffer mode
   output logic             crystal_oscillator_mode,  // buffer in crystal mode
   output logic             crystal_bias_off,         // oscillator bias disabled
   output logic             bypass_buf_en_chan_one,   // channel one buffer
   output logic             bypass_buf_en_chan_two,   // channel two buffer
   output logic             bypass_buf_en_chan_three, // channel three buffer
   output logic             bypass_buf_en_chan_four,  // channel four buffer
   output logic      [3:0]  chan_byp_route,           // gated bypass routes
   output logic             ref_copy_output_en,       // reference copy enable
   output logic             ref_copy_source_sel,      // 0 raw ref, 1 pfd
   output logic             ref_copy_output,          // selected copy level
   output logic             ref_divider_reset,        // holds divider flops
   output logic      [7:0]  ref_divider_value,        // divide ratio
   output logic             ref_doubler_en            // doubler selected
);
   // ======================================================================
   // register storage
   logic [15:0] crystal_and_input_buffer_config_r;  // first input word
   logic [15:0] input_bypass_and_ref_divider_r;     // second input word
   logic [2:0]  pin_sync_r;                         // pin reset synchroniser
   logic        pin_level_r;                        // filtered pin level
   logic        any_reset;                          // any reset source active
   logic        ref_copy_nxt;                       // selected copy source
   logic        div_rst_r;                          // divider reset register

   // ======================================================================
   // pin reset synchroniser, change counts when stages two and three agree
   always_ff @(posedge mclk) begin
      if (rst) begin
         pin_sync_r <= 3'h0;
      end else begin
         pin_sync_r <= {pin_sync_r[1:0], pin_reset};
      end
   end

   // filtered pin level
   always_ff @(posedge mclk) begin
      if (rst) begin
         pin_level_r <= 1'b0;
      end else if (pin_sync_r[1] == pin_sync_r[2]) begin
         pin_level_r <= pin_sync_r[2];
      end
   end

   assign any_reset = rst | sw_reset | pin_level_r;

   // ======================================================================
   // first input word: load cap, reserved pair, bias, buffer select
   always_ff @(posedge mclk) begin
      if (rst) begin
         crystal_and_input_buffer_config_r <= ref_input_pkg::crystal_cfg_reset;
      end else if (reg_wr && reg_addr == ref_input_pkg::addr_crystal_cfg) begin
         // all bits read-write, reserved pair stored as written
         crystal_and_input_buffer_config_r <= reg_wdata;
      end
   end

   // ======================================================================
   // second input word, all zero after reset
   always_ff @(posedge mclk) begin
      if (rst) begin
         input_bypass_and_ref_divider_r <= ref_input_pkg::bypass_rdiv_reset;
      end else if (reg_wr && reg_addr == ref_input_pkg::addr_bypass_rdiv) begin
         input_bypass_and_ref_divider_r <= reg_wdata;
      end
   end

   // ======================================================================
   // divider reset: forced during any reset, else register bit
   always_ff @(posedge mclk) begin
      if (any_reset) begin
         div_rst_r <= 1'b1;
      end else begin
         div_rst_r <= input_bypass_and_ref_divider_r[ref_input_pkg::rdiv_rst_bit];
      end
   end
   assign ref_divider_reset = div_rst_r | rst;

   // ======================================================================
   // read mux, unmapped address reads zero
   always_comb begin
      reg_rdata = 16'h0000;
      reg_hit   = 1'b0;
      if (reg_rd) begin
         case (reg_addr)
            ref_input_pkg::addr_crystal_cfg: begin
               reg_rdata = crystal_and_input_buffer_config_r;
               reg_hit   = 1'b1;
            end
            ref_input_pkg::addr_bypass_rdiv: begin
               reg_rdata = input_bypass_and_ref_divider_r;
               reg_hit   = 1'b1;
            end
            default: begin
               reg_rdata = 16'h0000;
               reg_hit   = 1'b0;
            end
         endcase
      end
   end

   // ======================================================================
   // first word field decode
   assign crystal_load_cap_sel = crystal_and_input_buffer_config_r[ref_input_pkg::cload_msb:
                                                                   ref_input_pkg::cload_lsb];
   assign crystal_bias_sel     = crystal_and_input_buffer_config_r[ref_input_pkg::bias_msb:
                                                                   ref_input_pkg::bias_lsb];
   assign input_buffer_sel     = crystal_and_input_buffer_config_r[ref_input_pkg::inbuf_msb:
                                                                   ref_input_pkg::inbuf_lsb];
   assign crystal_oscillator_mode = (input_buffer_sel == ref_input_pkg::inbuf_crystal);
   assign crystal_bias_off        = (crystal_bias_sel == ref_input_pkg::bias_disabled);

   // ======================================================================
   // second word field decode
   assign bypass_buf_en_chan_one   = input_bypass_and_ref_divider_r[ref_input_pkg::byp_chan_lsb];
   assign bypass_buf_en_chan_two   = input_bypass_and_ref_divider_r[ref_input_pkg::byp_chan_lsb+1];
   assign bypass_buf_en_chan_three = input_bypass_and_ref_divider_r[ref_input_pkg::byp_chan_lsb+2];
   assign bypass_buf_en_chan_four  = input_bypass_and_ref_divider_r[ref_input_pkg::byp_chan_msb];
   assign ref_copy_output_en  = input_bypass_and_ref_divider_r[ref_input_pkg::ref_copy_en_bit];
   assign ref_copy_source_sel = input_bypass_and_ref_divider_r[ref_input_pkg::ref_copy_sel_bit];
   assign ref_divider_value   = input_bypass_and_ref_divider_r[ref_input_pkg::rdiv_msb:
                                                               ref_input_pkg::rdiv_lsb];
   assign ref_doubler_en      = (ref_divider_value == ref_input_pkg::rdiv_doubler);

   // ======================================================================
   // per channel bypass buffer gates
   genvar ch;
   generate
      for (ch = 0; ch < ref_input_pkg::num_chan; ch++) begin : g_chan
         bypass_buf_gate u_gate (
            .mclk      (mclk),
            .rst       (rst),
            .buf_en    (input_bypass_and_ref_divider_r[ref_input_pkg::byp_chan_lsb + ch]),
            .byp_src   (chan_byp_req[ch]),
            .buf_on    (),
            .byp_route (chan_byp_route[ch])
         );
      end
   endgenerate

   // ======================================================================
   // reference copy source mux, registered and gated by enable
   // the output is re-timed to mclk, so it only follows slow levels; a
   // disabled copy parks low rather than passing a stale source level
   assign ref_copy_nxt = ref_copy_source_sel ? phase_detector_clock : ref_clk_sel_in;
   always_ff @(posedge mclk) begin
      if (rst) begin
         ref_copy_output <= 1'b0;
      end else begin
         ref_copy_output <= ref_copy_output_en & ref_copy_nxt;
      end
   end
endmodule

// ### verif/ref_input_config_chk.sv
// ========================================================
// port checker for the reference input registers
module ref_input_config_chk (
   input wire logic        mclk,
   input wire logic        rst,
   input wire logic        sw_reset,
   input wire logic [7:0]  reg_addr,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata,
   input wire logic        reg_hit,
   input wire logic [3:0]  chan_byp_req,
   input wire logic [3:0]  chan_byp_route,
   input wire logic [4:0]  crystal_load_cap_sel,
   input wire logic [3:0]  crystal_bias_sel,
   input wire logic [1:0]  input_buffer_sel,
   input wire logic        ref_copy_output_en,
   input wire logic        ref_copy_source_sel,
   input wire logic        ref_divider_reset,
   input wire logic [7:0]  ref_divider_value
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   // ========================================================
   // field values after reset, writes and reads
   a_reset_values: assert property (disable iff (1'b0) rst ##1 !rst |->
      {crystal_load_cap_sel, crystal_bias_sel, input_buffer_sel} == 11'h2d4 &&
      ref_divider_value == 8'h00 && ref_divider_reset) else $error("reset values wrong");
   a_first_word_write: assert property (reg_wr && reg_addr == 8'h1a |=>
      {crystal_load_cap_sel, crystal_bias_sel, input_buffer_sel} ==
      {$past(reg_wdata[12:8]), $past(reg_wdata[5:0])}) else $error("first word write lost");
   a_first_word_read: assert property (reg_rd && reg_addr == 8'h1a |-> reg_hit &&
      reg_rdata[12:0] == {crystal_load_cap_sel, reg_rdata[7:6], crystal_bias_sel,
      input_buffer_sel}) else $error("first word read wrong");
   a_second_word_write: assert property (reg_wr && reg_addr == 8'h1b |=>
      {ref_copy_output_en, ref_copy_source_sel, ref_divider_value} ==
      {$past(reg_wdata[10:9]), $past(reg_wdata[7:0])}) else $error("second word write lost");
   a_second_word_read: assert property (reg_rd && reg_addr == 8'h1b |-> reg_hit &&
      reg_rdata[10:0] == {ref_copy_output_en, ref_copy_source_sel, reg_rdata[8],
      ref_divider_value}) else $error("second word read wrong");
   a_unmapped_read: assert property (reg_rd && reg_addr != 8'h1a && reg_addr != 8'h1b |->
      !reg_hit && reg_rdata == 16'h0000) else $error("unmapped read not zero");
   a_chan_route: assert property (reg_wr && reg_addr == 8'h1b |-> ##2 chan_byp_route ==
      ($past(reg_wdata[14:11], 2) & $past(chan_byp_req))) else $error("bypass route wrong");
   a_divider_in_reset: assert property (disable iff (1'b0) rst || sw_reset |=>
      ref_divider_reset) else $error("divider not held in reset");
   cover property (reg_wr && reg_addr == 8'h1b);
   cover property (chan_byp_route != 4'h0);
   cover property (sw_reset ##1 ref_divider_reset);
endmodule
bind ref_input_config_regs ref_input_config_chk i_chk (.*);

// ### verif/ref_input_config_regs_tb.sv
module ref_input_config_regs_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        mclk, rst, sw_reset, pin_reset, reg_wr, reg_rd, reg_hit, ref_clk_sel_in;
   logic        phase_detector_clock, crystal_oscillator_mode, crystal_bias_off, ref_copy_output;
   logic        ref_copy_output_en, ref_copy_source_sel, ref_divider_reset, ref_doubler_en;
   logic        bypass_buf_en_chan_one, bypass_buf_en_chan_two;
   logic        bypass_buf_en_chan_three, bypass_buf_en_chan_four;
   logic [1:0]  input_buffer_sel;
   logic [3:0]  crystal_bias_sel, chan_byp_req, chan_byp_route;
   logic [4:0]  crystal_load_cap_sel;
   logic [7:0]  reg_addr, ref_divider_value;
   logic [15:0] reg_wdata, reg_rdata, w;
   int          n_errors, check_count;
   ref_input_config_regs i_dut (.*);
   // ========================================================
   // clock, watchdog and shared tasks
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   initial begin
      repeat (2000) @(posedge mclk);
      n_errors++;
      test_done;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] exp, input logic hit);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      #1;
      chk(reg_rdata, exp);
      chk({15'h0, reg_hit}, {15'h0, hit});
      @(posedge mclk);
      reg_rd <= 1'b0;
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic test_done;
      $display("mismatches %0d comparisons %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // ========================================================
   // scenarios
   task automatic t_first_word;
      for (int b = 0; b < 3; b++) begin
         w = {3'h0, 5'h1f - 5'(b), 2'(b), 4'hc - 4'(b), 2'(b)};
         wr(8'h1a, w);
         chk({11'h0, crystal_load_cap_sel}, {11'h0, w[12:8]});
         chk({12'h0, crystal_bias_sel}, {12'h0, w[5:2]});
         chk({14'h0, input_buffer_sel}, {14'h0, w[1:0]});
         chk({15'h0, crystal_oscillator_mode}, {15'h0, b == 0});
         rd(8'h1a, w, 1'b1);
      end
      wr(8'h1a, 16'h0000);
      chk({15'h0, crystal_bias_off}, 16'h0001);
   endtask
   task automatic t_second_word;
      @(posedge mclk);
      chan_byp_req <= 4'hf;
      ref_clk_sel_in <= 1'b0;
      phase_detector_clock <= 1'b1;
      for (int c = 0; c < 4; c++) begin
         wr(8'h1b, 16'h0800 << c);
         chk({12'h0, bypass_buf_en_chan_four, bypass_buf_en_chan_three, bypass_buf_en_chan_two,
            bypass_buf_en_chan_one}, 16'h0001 << c);
         step(1);
         chk({12'h0, chan_byp_route}, 16'h0001 << c);
      end
      wr(8'h1b, 16'h0600);
      step(1);
      chk({15'h0, ref_copy_output}, 16'h0001);
      chk({14'h0, ref_copy_output_en, ref_copy_source_sel}, 16'h0003);
      @(posedge mclk);
      ref_clk_sel_in <= 1'b1;
      phase_detector_clock <= 1'b0;
      wr(8'h1b, 16'h0400);
      step(1);
      chk({15'h0, ref_copy_output}, 16'h0001);
      chk({14'h0, ref_copy_output_en, ref_copy_source_sel}, 16'h0002);
      wr(8'h1b, 16'h80ff);
      step(1);
      chk({15'h0, ref_copy_output}, 16'h0000);
      chk({8'h0, ref_divider_value}, 16'h00ff);
      chk({15'h0, ref_doubler_en}, 16'h0000);
      rd(8'h1b, 16'h80ff, 1'b1);
      wr(8'h1b, 16'h0000);
      chk({15'h0, ref_doubler_en}, 16'h0001);
   endtask
   task automatic t_div_reset;
      wr(8'h1b, 16'h0100);
      step(1);
      chk({15'h0, ref_divider_reset}, 16'h0001);
      wr(8'h1b, 16'h0000);
      step(1);
      chk({15'h0, ref_divider_reset}, 16'h0000);
      @(posedge mclk);
      sw_reset <= 1'b1;
      @(posedge mclk);
      sw_reset <= 1'b0;
      #1;
      chk({15'h0, ref_divider_reset}, 16'h0001);
      @(posedge mclk);
      pin_reset <= 1'b1;
      step(5);
      chk({15'h0, ref_divider_reset}, 16'h0001);
      @(posedge mclk);
      pin_reset <= 1'b0;
      step(6);
      chk({15'h0, ref_divider_reset}, 16'h0000);
   endtask
   // ========================================================
   // main sequence: reset, scenarios, verdict
   initial begin
      {n_errors, check_count} = '0;
      {rst, sw_reset, pin_reset, reg_wr, reg_rd} = 5'h10;
      {reg_addr, reg_wdata, chan_byp_req, ref_clk_sel_in, phase_detector_clock} = '0;
      step(20);
      chk({15'h0, ref_divider_reset}, 16'h0001);
      @(posedge mclk);
      rst <= 1'b0;
      rd(8'h1a, 16'h0b14, 1'b1);
      rd(8'h1b, 16'h0000, 1'b1);
      t_first_word;
      t_second_word;
      t_div_reset;
      wr(8'h1c, 16'hffff);
      rd(8'h1c, 16'h0000, 1'b0);
      test_done;
   end
endmodule
